// [twr_defs.svh]
// Constants of the triggered waveform recorder: limits, defaults, sizes.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TWR_DEFS_SVH
`define TWR_DEFS_SVH

`define TWR_SPC_FULL      6'd32
`define TWR_SPC_HALF      6'd16
`define TWR_TOTAL_CYC     15'd725
`define TWR_TOTAL_WORDS   15'd23200
`define TWR_MAX_REC       7'd64
`define TWR_ONE_REC_CYC   15'd350
`define TWR_THREE_LO_CYC  15'd175
`define TWR_THREE_HI_CYC  15'd241
`define TWR_PRE_MAX       5'd25
`define TWR_PRE_DEPTH     10'd800
`define TWR_LEN_MIN       11'd5
`define TWR_LEN_MAX_FULL  11'd725
`define TWR_LEN_MAX_HALF  11'd1450
`define TWR_INT_MIN       10'd1
`define TWR_INT_MAX       10'd725
`define TWR_DIG_MAX       7'd80
`define TWR_UD_DIG_SLOTS  7'd16
`define TWR_N_ELEM        48
`define TWR_N_ANALOG      15
`define TWR_N_USER        5
`define TWR_FIFO_DEPTH    8

`define TWR_DEF_TRIP_REQ  1'b1
`define TWR_DEF_CONT      1'b0
`define TWR_DEF_RATE16    1'b0
`define TWR_DEF_PRE       5'd5
`define TWR_DEF_LEN       11'd5
`define TWR_DEF_INTERVAL  10'd4
`define TWR_DEF_MASK_ELEM 48'h0
`define TWR_DEF_MASK_EXT  1'b1

`endif

// [twr_pkg.sv]
// Types shared by the recorder: sample word, settings, memory write word.
// Assumes twr_defs.svh is on the include path.
`include "twr_defs.svh"

package twr_pkg;

	typedef struct packed {
		logic [`TWR_N_ANALOG-1:0][15:0] analog;
		logic [`TWR_N_USER-1:0][15:0]   user;
		logic [79:0]                    digital;
	} twr_sample_t;

	typedef struct packed {
		logic                    trip_req;
		logic                    cont;
		logic                    rate16;
		logic [4:0]              pre;
		logic [10:0]             len;
		logic [9:0]              interval;
		logic [`TWR_N_ANALOG-1:0] ana_en;
		logic [`TWR_N_USER-1:0]  user_en;
		logic [`TWR_N_USER-1:0]  user_sine;
		logic [`TWR_N_ELEM-1:0]  mask_elem;
		logic                    mask_ext;
	} twr_cfg_t;

	typedef struct packed {
		logic [14:0] addr;
		twr_sample_t data;
	} twr_nvm_t;

	typedef enum logic [2:0] {
		TWR_IDLE  = 3'b001,
		TWR_CAPT  = 3'b010,
		TWR_ERASE = 3'b100
	} twr_state_t;

endpackage : twr_pkg

// [twr_recorder.sv]
// Triggered waveform recorder core and its output FIFO.
// Assumes synchronous sample and pickup inputs, and an external record
// memory that takes one addressed word per accepted FIFO output beat.
//
// How it works
// [RULE1] Fixed variant stores every channel at 32 samples per cycle.
// [RULE2] Selectable variant stores 32 or 16 per cycle; 16 doubles capacity.
// [RULE3] Up to 64 records kept in cyclically managed memory.
// [RULE4] Each sample stored at sampling resolution; start time stamped.
// [RULE5] Fifteen analog channels, each gated by its own enable.
// [RULE6] Up to five user values recorded beside analog channels.
// [RULE7] Digital slots capped at 80, minus 16 per enabled user value.
// [RULE8] Sinusoidal user values are stored as their RMS value.
// [RULE9] Each trigger source starts capture only when its mask is set.
// [RULE10] Element pickup masks come out of reset disabled.
// [RULE11] Delete-all erases the whole record memory.
// [RULE12] With trip required, a capture without trip is discarded.
// [RULE13] Continuous mode: new pickup while originator active restarts count.
// [RULE14] Memory split into zones sized by record length; one record each.
// [RULE15] Later triggers extend the record by at most the interval.
// [RULE16] Trigger interval 1 to 725 cycles, default 4, sets spacing.
// [RULE17] Pre-trigger length 0 to 25 cycles, default 5.
// [RULE18] When memory is full the oldest record is overwritten.
// [RULE19] Total memory 725 cycles; record count follows the length.
// [RULE20] Lengths above 350 cycles leave room for one record only.
// [RULE21] Dedicated external trigger input, gated by its own mask.
// [RULE22] Circular pre-trigger buffer is written continuously.
`include "twr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module twr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} twr_fifo_st_t;

	twr_fifo_st_t   st_r;
	twr_fifo_st_t   st_nxt;
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic           push;
	logic           pop;

	assign in_ready  = (st_r.cnt != DEPTH[AW:0]);
	assign out_valid = (st_r.cnt != '0);
	assign out_data  = mem[st_r.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		st_nxt = st_r;
		if (push)
			st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
		if (pop)
			st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
		if (push && !pop)
			st_nxt.cnt = st_r.cnt + 1'b1;
		else if (pop && !push)
			st_nxt.cnt = st_r.cnt - 1'b1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Storage carries no reset; only pointers decide what is valid
	always_ff @(posedge clk)
	begin
		if (push)
			mem[st_r.wp] <= in_data;
	end
endmodule : twr_fifo

module twr_recorder
	import twr_pkg::*;
#(
	parameter bit SEL_RATE = 1'b1
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    sample_valid,
	output logic                         sample_ready,
	input  wire twr_sample_t             sample,
	input  wire logic [`TWR_N_USER-1:0][15:0] user_rms,
	input  wire logic [`TWR_N_ELEM-1:0]  pickups,
	input  wire logic                    external_record_trigger,
	input  wire logic                    trip,
	input  wire logic [63:0]             time_now,
	input  wire twr_cfg_t                cfg_in,
	input  wire logic                    cfg_load,
	input  wire logic                    delete_all_records,
	output logic                         nvm_valid,
	input  wire logic                    nvm_ready,
	output twr_nvm_t                     nvm_word,
	output logic                         busy,
	output logic                         erasing,
	output logic                         rec_done,
	output logic                         rec_kept,
	output logic [5:0]                   rec_zone,
	output logic [63:0]                  rec_stamp,
	output logic [6:0]                   rec_count,
	output logic [5:0]                   rec_oldest,
	output logic [6:0]                   zone_count
);
	localparam int NS = `TWR_N_ELEM + 1;

	typedef struct packed {
		twr_state_t  state;
		twr_cfg_t    cfg;
		logic [6:0]  zones;
		logic [14:0] zone_words;
		logic [5:0]  head;
		logic [6:0]  count;
		logic [9:0]  wr_idx;
		logic        phase;
		logic [NS-1:0] src_d;
		logic [NS-1:0] origin;
		logic        tripped;
		logic [14:0] used;
		logic [14:0] rem;
		logic [14:0] since;
		logic [14:0] base;
		logic [63:0] stamp;
		logic [14:0] erase_addr;
		logic        rec_done;
		logic        rec_kept;
		logic [5:0]  rec_zone;
		logic [63:0] rec_stamp;
	} twr_core_t;

	twr_core_t   st_r;
	twr_core_t   st_nxt;
	twr_sample_t pre_mem [0:`TWR_PRE_DEPTH-1];
	twr_sample_t proc;
	twr_sample_t delayed;
	twr_cfg_t    cfg_clamped;
	twr_cfg_t    cfg_default;
	logic        fifo_in_ready;
	logic        fifo_in_valid;
	twr_nvm_t    fifo_in_word;
	logic        acc;
	logic        store;
	logic [5:0]  spc;
	logic [9:0]  delay;
	logic [9:0]  rd_idx;
	logic [NS-1:0] src_en;
	logic [NS-1:0] rise;
	logic [14:0] len_s;
	logic [14:0] intv_s;
	logic [14:0] room;
	logic [14:0] norm;
	logic [14:0] zones_raw;
	logic [14:0] zone_cyc;
	logic [6:0]  dig_allow;
	logic        retrig;
	logic        keep;

	// Restoring divider; settings change rarely, so depth is no concern
	function automatic logic [14:0] twr_div(input logic [14:0] a,
		input logic [14:0] b);
		logic [15:0] r;
		logic [14:0] q;
		r = '0;
		q = '0;
		for (int i = 14; i >= 0; i--)
		begin
			r = {r[14:0], a[i]};
			if (r >= {1'b0, b})
			begin
				r = r - {1'b0, b};
				q[i] = 1'b1;
			end
		end
		return q;
	endfunction : twr_div

	always_comb
	begin
		cfg_default = '0;
		cfg_default.trip_req  = `TWR_DEF_TRIP_REQ;
		cfg_default.cont      = `TWR_DEF_CONT;
		cfg_default.rate16    = `TWR_DEF_RATE16;
		cfg_default.pre       = `TWR_DEF_PRE;
		cfg_default.len       = `TWR_DEF_LEN;
		cfg_default.interval  = `TWR_DEF_INTERVAL;
		cfg_default.ana_en    = '1;
		cfg_default.mask_elem = `TWR_DEF_MASK_ELEM; // [RULE10]
		cfg_default.mask_ext  = `TWR_DEF_MASK_EXT;
	end

	// Out-of-range settings are clamped rather than rejected
	always_comb
	begin
		cfg_clamped = cfg_in;
		cfg_clamped.rate16 = SEL_RATE && cfg_in.rate16; // [RULE1] [RULE2]
		if (cfg_in.pre > `TWR_PRE_MAX)
			cfg_clamped.pre = `TWR_PRE_MAX; // [RULE17]
		if (cfg_in.len < `TWR_LEN_MIN)
			cfg_clamped.len = `TWR_LEN_MIN;
		else if (cfg_clamped.rate16 && cfg_in.len > `TWR_LEN_MAX_HALF)
			cfg_clamped.len = `TWR_LEN_MAX_HALF; // [RULE2]
		else if (!cfg_clamped.rate16 && cfg_in.len > `TWR_LEN_MAX_FULL)
			cfg_clamped.len = `TWR_LEN_MAX_FULL;
		if (cfg_in.interval < `TWR_INT_MIN)
			cfg_clamped.interval = `TWR_INT_MIN; // [RULE16]
		else if (cfg_in.interval > `TWR_INT_MAX)
			cfg_clamped.interval = `TWR_INT_MAX;
	end

	// Zone layout from the clamped length, in full-rate cycle units
	always_comb
	begin
		norm = cfg_clamped.rate16 ? 15'({1'b0, cfg_clamped.len} + 12'd1) >> 1
			: 15'(cfg_clamped.len);
		zones_raw = twr_div(`TWR_TOTAL_CYC, norm); // [RULE19]
		if (zones_raw > 15'(`TWR_MAX_REC))
			zones_raw = 15'(`TWR_MAX_REC); // [RULE3]
		if (norm > `TWR_ONE_REC_CYC)
			zones_raw = 15'd1; // [RULE20]
		else if (norm >= `TWR_THREE_LO_CYC && norm <= `TWR_THREE_HI_CYC)
			zones_raw = 15'd3; // [RULE19]
		zone_cyc = twr_div(`TWR_TOTAL_CYC, zones_raw); // [RULE14]
	end

	// Channel selection and formatting before buffering
	always_comb
	begin
		proc = '0;
		dig_allow = `TWR_DIG_MAX;
		for (int i = 0; i < `TWR_N_ANALOG; i++)
			if (st_r.cfg.ana_en[i])
				proc.analog[i] = sample.analog[i]; // [RULE5]
		for (int i = 0; i < `TWR_N_USER; i++)
			if (st_r.cfg.user_en[i])
			begin
				proc.user[i] = st_r.cfg.user_sine[i] ? user_rms[i]
					: sample.user[i]; // [RULE6] [RULE8]
				dig_allow = dig_allow - `TWR_UD_DIG_SLOTS; // [RULE7]
			end
		for (int i = 0; i < 80; i++)
			if (7'(i) < dig_allow)
				proc.digital[i] = sample.digital[i]; // [RULE7]
	end

	assign spc    = st_r.cfg.rate16 ? `TWR_SPC_HALF : `TWR_SPC_FULL;
	assign acc    = sample_valid && sample_ready;
	assign store  = acc && (!st_r.cfg.rate16 || !st_r.phase); // [RULE2]
	// Operands widened first so the product cannot wrap
	assign delay  = 10'(st_r.cfg.pre) * 10'(spc);
	assign rd_idx = (st_r.wr_idx >= delay) ? st_r.wr_idx - delay
		: 10'(st_r.wr_idx + `TWR_PRE_DEPTH - delay);
	// Zero pre-trigger means the live sample goes straight to memory
	assign delayed = (delay == '0) ? proc : pre_mem[rd_idx]; // [RULE17]

	assign src_en = {external_record_trigger, pickups}
		& {st_r.cfg.mask_ext, st_r.cfg.mask_elem}; // [RULE9] [RULE21]
	assign rise   = src_en & ~st_r.src_d;
	assign len_s  = 15'(st_r.cfg.len) * 15'(spc);
	assign intv_s = 15'(st_r.cfg.interval) * 15'(spc);
	assign room   = st_r.zone_words - st_r.used;
	assign retrig = st_r.cfg.cont && |(rise & ~st_r.origin)
		&& |(src_en & st_r.origin) && st_r.since >= intv_s; // [RULE13]
	assign keep   = !st_r.cfg.trip_req || st_r.tripped || trip; // [RULE12]

	// Erase stalls the source so no live sample is half-handled
	assign sample_ready = (st_r.state != TWR_ERASE) && fifo_in_ready;

	always_comb
	begin
		fifo_in_valid = 1'b0;
		fifo_in_word  = '0;
		if (st_r.state == TWR_ERASE)
		begin
			fifo_in_valid      = 1'b1;
			fifo_in_word.addr  = st_r.erase_addr; // [RULE11]
		end
		else if (st_r.state == TWR_CAPT && store)
		begin
			fifo_in_valid      = 1'b1;
			fifo_in_word.addr  = st_r.base + st_r.used; // [RULE4] [RULE14]
			fifo_in_word.data  = delayed;
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rec_done = 1'b0;
		st_nxt.src_d = src_en;
		if (acc && st_r.cfg.rate16)
			st_nxt.phase = !st_r.phase;
		if (store)
			st_nxt.wr_idx = (st_r.wr_idx == `TWR_PRE_DEPTH - 10'd1) ? '0
				: st_r.wr_idx + 10'd1; // [RULE22]
		if (delete_all_records)
		begin
			st_nxt.state = TWR_ERASE; // [RULE11]
			st_nxt.erase_addr = '0;
			st_nxt.head = '0;
			st_nxt.count = '0;
		end
		else if (cfg_load)
		begin
			// New layout invalidates every stored zone
			st_nxt.cfg = cfg_clamped;
			st_nxt.zones = zones_raw[6:0];
			st_nxt.zone_words = 15'(zone_cyc * `TWR_SPC_FULL);
			st_nxt.head = '0;
			st_nxt.count = '0;
			st_nxt.phase = 1'b0;
			if (st_r.state == TWR_CAPT)
				st_nxt.state = TWR_IDLE;
		end
		else
		begin
			unique case (st_r.state)
				TWR_IDLE:
				begin
					if (|rise)
					begin
						st_nxt.state = TWR_CAPT; // [RULE9]
						st_nxt.origin = rise;
						st_nxt.stamp = time_now; // [RULE4]
						st_nxt.used = '0;
						st_nxt.rem = (len_s > st_r.zone_words)
							? st_r.zone_words : len_s;
						st_nxt.since = '0;
						st_nxt.tripped = trip;
						st_nxt.base = 15'(st_r.head * st_r.zone_words);
					end
				end
				TWR_CAPT:
				begin
					if (trip)
						st_nxt.tripped = 1'b1; // [RULE12]
					if (store)
					begin
						st_nxt.used = st_r.used + 15'd1;
						st_nxt.rem = st_r.rem - 15'd1;
						if (st_r.since != '1)
							st_nxt.since = st_r.since + 15'd1;
					end
					if (retrig)
					begin
						st_nxt.since = '0;
						// Extension limited to the interval and the zone
						if (intv_s > st_nxt.rem)
							st_nxt.rem = (intv_s > room) ? room
								: intv_s; // [RULE15] [RULE16]
						st_nxt.origin = st_r.origin | rise;
					end
					if (store && st_r.rem == 15'd1 && !(retrig && intv_s > 15'd1))
					begin
						st_nxt.state = TWR_IDLE;
						st_nxt.rec_done = 1'b1;
						st_nxt.rec_kept = keep;
						st_nxt.rec_zone = st_r.head;
						st_nxt.rec_stamp = st_r.stamp;
						if (keep)
						begin
							st_nxt.head = (7'(st_r.head) + 7'd1 >= st_r.zones)
								? '0 : st_r.head + 6'd1; // [RULE18]
							if (st_r.count < st_r.zones)
								st_nxt.count = st_r.count + 7'd1; // [RULE3]
						end
					end
				end
				TWR_ERASE:
				begin
					if (fifo_in_ready)
					begin
						st_nxt.erase_addr = st_r.erase_addr + 15'd1;
						if (st_r.erase_addr == `TWR_TOTAL_WORDS - 15'd1)
							st_nxt.state = TWR_IDLE; // [RULE11]
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= '0;
			st_r.state <= TWR_IDLE;
			st_r.cfg.trip_req <= `TWR_DEF_TRIP_REQ;
			st_r.cfg.pre <= `TWR_DEF_PRE;
			st_r.cfg.len <= `TWR_DEF_LEN;
			st_r.cfg.interval <= `TWR_DEF_INTERVAL;
			st_r.cfg.ana_en <= '1;
			st_r.cfg.mask_elem <= `TWR_DEF_MASK_ELEM; // [RULE10]
			st_r.cfg.mask_ext <= `TWR_DEF_MASK_EXT;
			st_r.zones <= `TWR_MAX_REC;
			st_r.zone_words <= 15'd352;
		end
		else
			st_r <= st_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (store)
			pre_mem[st_r.wr_idx] <= proc; // [RULE22]
	end

	twr_fifo #(
		.WIDTH ($bits(twr_nvm_t)),
		.DEPTH (`TWR_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_word),
		.out_valid (nvm_valid),
		.out_ready (nvm_ready),
		.out_data  (nvm_word)
	);

	assign busy       = (st_r.state != TWR_IDLE);
	assign erasing    = (st_r.state == TWR_ERASE);
	assign rec_done   = st_r.rec_done;
	assign rec_kept   = st_r.rec_kept;
	assign rec_zone   = st_r.rec_zone;
	assign rec_stamp  = st_r.rec_stamp;
	assign rec_count  = st_r.count;
	assign zone_count = st_r.zones;
	assign rec_oldest = (7'(st_r.head) >= st_r.count)
		? 6'(7'(st_r.head) - st_r.count)
		: 6'(7'(st_r.head) + st_r.zones - st_r.count); // [RULE18]

	// Unused default copy kept equal to reset for clarity of intent
	logic unused_defaults;
	assign unused_defaults = ^cfg_default;
endmodule : twr_recorder

`default_nettype wire

// [twr_recorder_chk.sv]
// Port-level checker of the waveform recorder, bound to twr_recorder.
// Assumes one clock domain with the asynchronous active-low rstn.
`include "twr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module twr_recorder_chk
	import twr_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rstn,
	input wire logic                   sample_ready,
	input wire logic [`TWR_N_ELEM-1:0] pickups,
	input wire logic                   external_record_trigger,
	input wire logic                   cfg_load,
	input wire logic                   delete_all_records,
	input wire logic                   nvm_valid,
	input wire logic                   nvm_ready,
	input wire twr_nvm_t               nvm_word,
	input wire logic                   busy,
	input wire logic                   erasing,
	input wire logic                   rec_done,
	input wire logic                   rec_kept,
	input wire logic [5:0]             rec_zone,
	input wire logic [6:0]             rec_count,
	input wire logic [5:0]             rec_oldest,
	input wire logic [6:0]             zone_count
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_done_pulse;
		rec_done |=> !rec_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("rec_done longer than one cycle");
	property p_erase_start;
		delete_all_records |=> erasing;
	endproperty
	a_erase_start: assert property (p_erase_start)
		else $error("erase did not start");
	property p_erase_block;
		erasing |-> !sample_ready;
	endproperty
	a_erase_block: assert property (p_erase_block)
		else $error("samples accepted while erasing");
	property p_hold;
		nvm_valid && !nvm_ready |=> nvm_valid && $stable(nvm_word);
	endproperty
	a_hold: assert property (p_hold)
		else $error("memory word dropped or changed while stalled");
	property p_start_cause;
		$rose(busy) |-> $past(|pickups || external_record_trigger
			|| delete_all_records);
	endproperty
	a_start_cause: assert property (p_start_cause)
		else $error("capture started without any source");
	property p_count_cap;
		rec_count <= zone_count && zone_count <= `TWR_MAX_REC
			&& zone_count != 7'h0;
	endproperty
	a_count_cap: assert property (p_count_cap)
		else $error("record or zone count out of range");
	property p_zone_ok;
		rec_done |-> rec_zone < zone_count;
	endproperty
	a_zone_ok: assert property (p_zone_ok)
		else $error("record zone beyond zone count");
	property p_addr_ok;
		nvm_valid |-> nvm_word.addr < `TWR_TOTAL_WORDS;
	endproperty
	a_addr_ok: assert property (p_addr_ok)
		else $error("memory address beyond total size");
	property p_discard;
		rec_done && !rec_kept |=> $stable(rec_count) && $stable(rec_oldest);
	endproperty
	a_discard: assert property (p_discard)
		else $error("discarded record changed the store");
	property p_abort;
		cfg_load && !delete_all_records && !erasing |=> !busy;
	endproperty
	a_abort: assert property (p_abort)
		else $error("capture survived a configuration load");

	c_kept: cover property (rec_done && rec_kept);
	c_dropped: cover property (rec_done && !rec_kept);
	c_erase: cover property ($fell(erasing));
	c_stall: cover property (nvm_valid && !nvm_ready && !sample_ready);
endmodule : twr_recorder_chk

bind twr_recorder twr_recorder_chk u_chk (.clk(clk), .rstn(rstn),
	.sample_ready(sample_ready), .pickups(pickups),
	.external_record_trigger(external_record_trigger),
	.cfg_load(cfg_load), .delete_all_records(delete_all_records),
	.nvm_valid(nvm_valid), .nvm_ready(nvm_ready), .nvm_word(nvm_word),
	.busy(busy), .erasing(erasing), .rec_done(rec_done),
	.rec_kept(rec_kept), .rec_zone(rec_zone), .rec_count(rec_count),
	.rec_oldest(rec_oldest), .zone_count(zone_count));
`default_nettype wire

// [twr_sample_src.sv]
// Model of the sampled measurement channels feeding the recorder.
// Assumes the recorder takes a word on valid and ready at a rising edge.
`timescale 1ns/1ps
`default_nettype none

module twr_sample_src
	import twr_pkg::*;
(
	input wire logic  clk,
	input wire logic  rstn,
	input wire logic  sample_ready,
	output logic      sample_valid,
	output twr_sample_t sample
);
	logic [15:0] idx_r;

	// Stream never pauses, so the pre-trigger buffer always fills
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			idx_r        <= 16'h1;
			sample_valid <= 1'b0;
		end
		else
		begin
			sample_valid <= 1'b1;
			if (sample_valid && sample_ready)
				idx_r <= idx_r + 16'h1;
		end

	// Held until accepted; analog, user 0 and digital follow the index so no word looks erased
	always_comb
	begin
		sample = '0;
		for (int i = 0; i < 15; i++)
			sample.analog[i] = idx_r ^ 16'(i << 12);
		sample.user[0] = ~idx_r;
		sample.digital = {64'h0, idx_r};
	end
endmodule : twr_sample_src
`default_nettype wire

// [twr_recorder_test.sv]
// Self-checking bench of the recorder with a sample stream model.
// Assumes capture length len*spc words and zone start head*zone_words.
`timescale 1ns/1ps
`default_nettype none

module twr_recorder_test;
	import twr_pkg::*;
	logic clk, rstn, sample_valid, sample_ready, ext, trip, cfg_load, del;
	logic nvm_valid, nvm_ready, busy, erasing, rec_done, rec_kept;
	logic [47:0] pickups;
	logic [63:0] time_now = 64'h100;
	logic [63:0] rec_stamp, stamp_exp;
	logic [15:0] idx0;
	logic [5:0]  rec_zone, rec_oldest;
	logic [6:0]  rec_count, zone_count;
	logic [14:0] first_addr;
	twr_sample_t sample;
	twr_sample_t first_data;
	twr_cfg_t    cfg_in;
	twr_nvm_t    nvm_word;
	int miscompares, checked, beats, mark, nonzero, cycles;

	twr_sample_src src (.clk(clk), .rstn(rstn), .sample_ready(sample_ready),
		.sample_valid(sample_valid), .sample(sample));
	twr_recorder #(.SEL_RATE(1'b1)) uut (.clk(clk), .rstn(rstn),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample(sample), .user_rms('0), .pickups(pickups),
		.external_record_trigger(ext), .trip(trip), .time_now(time_now),
		.cfg_in(cfg_in), .cfg_load(cfg_load), .delete_all_records(del),
		.nvm_valid(nvm_valid), .nvm_ready(nvm_ready), .nvm_word(nvm_word),
		.busy(busy), .erasing(erasing), .rec_done(rec_done),
		.rec_kept(rec_kept), .rec_zone(rec_zone), .rec_stamp(rec_stamp),
		.rec_count(rec_count), .rec_oldest(rec_oldest),
		.zone_count(zone_count));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Memory side: counts beats, notes first address, spots nonzero data
	always @(posedge clk)
	begin
		time_now <= time_now + 64'h1;
		cycles++;
		if (cycles == 90000)
		begin
			miscompares++;
			conclude();
		end
		if (nvm_valid === 1'b1 && nvm_ready === 1'b1)
		begin
			if (beats == mark)
			begin
				first_addr = nvm_word.addr;
				first_data = nvm_word.data;
			end
			if (nvm_word.data !== '0)
				nonzero++;
			beats++;
		end
	end

	task automatic check(input string name, input logic [63:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic conclude();
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	function automatic twr_cfg_t mk(input logic [10:0] len,
		input logic tr, r16, mext, input logic [47:0] mel);
		mk = '0;
		mk.trip_req = tr;
		mk.rate16 = r16;
		mk.pre = 5'h5;
		mk.len = len;
		mk.interval = 10'h4;
		mk.ana_en = '1;
		mk.mask_elem = mel;
		mk.mask_ext = mext;
	endfunction : mk

	task automatic load(input twr_cfg_t c);
		@(posedge clk);
		cfg_in <= c;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		@(posedge clk);
	endtask : load

	// Level source held three cycles, stamp due at the taking edge
	task automatic fire(input logic e, input int b);
		@(posedge clk);
		mark = beats;
		if (e)
			ext <= 1'b1;
		else
			pickups[b] <= 1'b1;
		#1 stamp_exp = time_now;
		repeat (3) @(posedge clk);
		ext <= 1'b0;
		pickups <= '0;
	endtask : fire

	task automatic rec(input int words, input logic kept,
		input logic [5:0] zone, input logic [14:0] a0, input logic [6:0] n);
		int k;
		k = 0;
		do
		begin
			@(posedge clk);
			#1 k++;
		end while (rec_done !== 1'b1 && k < 9000);
		check("rec_kept", rec_kept, kept);
		check("rec_zone", rec_zone, zone);
		check("rec_stamp", rec_stamp, stamp_exp);
		while (nvm_valid !== 1'b0 && k < 9050)
		begin
			@(posedge clk);
			#1 k++;
		end
		check("words", beats - mark, words);
		check("first_addr", first_addr, a0);
		check("rec_count", rec_count, n);
	endtask : rec

	task automatic t_reset();
		check("zone_count", zone_count, 7'h40);
		check("rec_count", rec_count, 7'h0);
		pickups <= '1;
		repeat (4) @(posedge clk);
		pickups <= '0;
		#1 check("busy", busy, 1'b0);
		fire(1'b1, 0);
		#1 check("busy", busy, 1'b1);
		rec(160, 1'b0, 6'h0, 15'h0, 7'h0);
	endtask : t_reset

	// Memory side stalls until the input side refuses samples
	task automatic t_stall();
		load(mk(11'h5, 1'b0, 1'b0, 1'b1, '0));
		fire(1'b1, 0);
		nvm_ready <= 1'b0;
		repeat (20) @(posedge clk);
		#1 check("sample_ready", sample_ready, 1'b0);
		check("nvm_valid", nvm_valid, 1'b1);
		@(posedge clk);
		nvm_ready <= 1'b1;
		rec(160, 1'b1, 6'h0, 15'h0, 7'h1);
	endtask : t_stall

	task automatic t_trip();
		load(mk(11'h5, 1'b1, 1'b0, 1'b1, '0));
		fire(1'b1, 0);
		rec(160, 1'b0, 6'h0, 15'h0, 7'h0);
		fire(1'b1, 0);
		trip <= 1'b1;
		@(posedge clk);
		trip <= 1'b0;
		rec(160, 1'b1, 6'h0, 15'h0, 7'h1);
	endtask : t_trip

	task automatic t_mask();
		load(mk(11'h5, 1'b0, 1'b0, 1'b0, 48'h80));
		fire(1'b1, 0);
		#1 check("busy", busy, 1'b0);
		fire(1'b0, 3);
		#1 check("busy", busy, 1'b0);
		fire(1'b0, 7);
		rec(160, 1'b1, 6'h0, 15'h0, 7'h1);
	endtask : t_mask

	// Second source after 140 stores makes the record run one interval past it, 268 words
	task automatic t_cont();
		twr_cfg_t c;
		c = mk(11'h5, 1'b0, 1'b0, 1'b1, 48'h80);
		c.cont = 1'b1;
		c.pre = 5'h0;
		c.ana_en = 15'h7ffe;
		c.user_en = 5'h1;
		c.user_sine = 5'h1;
		load(c);
		@(posedge clk);
		mark = beats;
		ext <= 1'b1;
		#1 stamp_exp = time_now;
		idx0 = src.idx_r;
		repeat (140) @(posedge clk);
		pickups[7] <= 1'b1;
		repeat (3) @(posedge clk);
		ext <= 1'b0;
		pickups <= '0;
		rec(268, 1'b1, 6'h0, 15'h0, 7'h1);
		check("live", first_data.digital[15:0], idx0 + 16'h1);
		check("ana_off", first_data.analog[0], 16'h0);
		check("rms", first_data.user[0], 16'h0);
	endtask : t_cont

	task automatic t_zones();
		logic [10:0] lz[9] = '{725, 350, 175, 241, 242, 22, 11, 400, 1450};
		logic [6:0]  ez[9] = '{1, 2, 3, 3, 2, 32, 64, 1, 1};
		for (int i = 0; i < 9; i++)
		begin
			load(mk(lz[i], 1'b0, i == 8, 1'b1, '0));
			check("zone_count", zone_count, ez[i]);
		end
		load(mk(11'h5, 1'b0, 1'b1, 1'b1, '0));
		fire(1'b1, 0);
		rec(80, 1'b1, 6'h0, 15'h0, 7'h1);
	endtask : t_zones

	// Three zones of 241 cycles each; the fourth record reuses zone 0
	task automatic t_wrap();
		load(mk(11'd175, 1'b0, 1'b0, 1'b1, '0));
		for (int i = 0; i < 4; i++)
		begin
			fire(1'b1, 0);
			rec(5600, 1'b1, 6'(i % 3), 15'((i % 3) * 7712),
				7'((i > 2) ? 3 : i + 1));
		end
		check("rec_oldest", rec_oldest, 6'h1);
	endtask : t_wrap

	task automatic t_erase();
		int k;
		mark = beats;
		k = nonzero;
		@(posedge clk);
		del <= 1'b1;
		@(posedge clk);
		del <= 1'b0;
		repeat (30000)
		begin
			@(posedge clk);
			#1 if (erasing === 1'b0 && nvm_valid === 1'b0)
				break;
		end
		check("erase_words", beats - mark, 23200);
		check("erase_nonzero", nonzero - k, 0);
		check("rec_count", rec_count, 7'h0);
	endtask : t_erase

	initial
	begin
		rstn = 1'b0;
		ext = 1'b0;
		trip = 1'b0;
		cfg_load = 1'b0;
		del = 1'b0;
		nvm_ready = 1'b1;
		pickups = '0;
		cfg_in = '0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_stall();
		t_trip();
		t_mask();
		t_cont();
		t_zones();
		t_wrap();
		t_erase();
		conclude();
	end
endmodule : twr_recorder_test
`default_nettype wire
